// [rtl/awc_exec.sv]
`timescale 1ns/100ps
// Operation
// - Result is destination plus source plus carry.
// - Opcodes 12-17 select register-form addressing modes.
// - Opcodes 18, 19 select extended forms.
// - Set C Z S V H; clear D.
// - Fetch takes 2, 3 or 4 cycles.
// - Execution takes 3 or 4 cycles.
module awc_exec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input awc_pkg::awc_req_s req,
  input wire logic [7:0] flags_in,
  output logic ready,
  output logic busy,
  output logic fetching,
  output logic illegal_ff,
  output logic done_ff,
  output logic [7:0] result_ff,
  output logic [7:0] flags_ff,
  output awc_pkg::awc_mode_e mode_ff,
  output logic extended_ff
);

  typedef enum logic [2:0] {
    AWC_S_IDLE = 3'b001,
    AWC_S_FETCH = 3'b010,
    AWC_S_EXEC = 3'b100
  } awc_state_e;

  awc_pkg::awc_dec_s dec;
  awc_state_e state_ff;
  logic [2:0] cnt_ff;
  logic [2:0] exec_len_ff;
  logic [7:0] dst_ff;
  logic [7:0] src_ff;
  logic carry_ff;
  logic [7:0] in_flags_ff;
  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] nxt_flags;
  logic last_exec;

  awc_decode u_dec (
    .opcode(req.opcode),
    .dec(dec)
  );

  assign ready = (state_ff == AWC_S_IDLE);
  assign busy = !ready;
  assign fetching = (state_ff == AWC_S_FETCH);
  assign last_exec = (state_ff == AWC_S_EXEC) && (cnt_ff == 3'h1);

  // Sequencer: fetch count then execution count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= AWC_S_IDLE;
      cnt_ff <= 3'h0;
      exec_len_ff <= 3'h0;
    end else begin
      case (state_ff)
        AWC_S_IDLE: begin
          if (start && dec.valid) begin
            state_ff <= AWC_S_FETCH;
            cnt_ff <= dec.fetch_cycles;
            exec_len_ff <= dec.exec_cycles;
          end
        end
        AWC_S_FETCH: begin
          if (cnt_ff == 3'h1) begin
            state_ff <= AWC_S_EXEC;
            cnt_ff <= exec_len_ff;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        AWC_S_EXEC: begin
          if (cnt_ff == 3'h1) begin
            state_ff <= AWC_S_IDLE;
            cnt_ff <= 3'h0;
          end else begin
            cnt_ff <= cnt_ff - 3'h1;
          end
        end
        default: state_ff <= AWC_S_IDLE;
      endcase
    end
  end

  // Operand and carry capture at acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dst_ff <= 8'h00;
      src_ff <= 8'h00;
      carry_ff <= 1'b0;
      in_flags_ff <= awc_pkg::FLAGS_RESET;
      mode_ff <= awc_pkg::AWC_M_NONE;
      extended_ff <= 1'b0;
    end else if (ready && start && dec.valid) begin
      dst_ff <= req.dst;
      src_ff <= req.src;
      carry_ff <= flags_in[awc_pkg::FLAG_C];
      in_flags_ff <= flags_in;
      mode_ff <= dec.mode;
      extended_ff <= dec.extended;
    end
  end

  // Sum and flag computation
  always_comb begin
    sum = {1'b0, dst_ff} + {1'b0, src_ff} + {8'h00, carry_ff};
    half = {1'b0, dst_ff[3:0]} + {1'b0, src_ff[3:0]} + {4'h0, carry_ff};
    nxt_flags = in_flags_ff;
    nxt_flags[awc_pkg::FLAG_C] = sum[8];
    nxt_flags[awc_pkg::FLAG_Z] = (sum[7:0] == 8'h00);
    nxt_flags[awc_pkg::FLAG_S] = sum[7];
    nxt_flags[awc_pkg::FLAG_V] = (dst_ff[7] == src_ff[7]) && (sum[7] != dst_ff[7]);
    nxt_flags[awc_pkg::FLAG_D] = 1'b0;
    nxt_flags[awc_pkg::FLAG_H] = half[4];
  end

  // Write-back of result and flags together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= 8'h00;
      flags_ff <= awc_pkg::FLAGS_RESET;
      done_ff <= 1'b0;
    end else begin
      done_ff <= last_exec;
      if (last_exec) begin
        result_ff <= sum[7:0];
        flags_ff <= nxt_flags;
      end
    end
  end

  // Unknown opcode offered while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= ready && start && !dec.valid;
    end
  end

  // Phase shapes: fetch counted from the cycle after the take, execution from the cycle after fetch ends
  sequence fetch_two_s;
    fetching [*2];
  endsequence

  sequence fetch_three_s;
    fetching [*3];
  endsequence

  sequence fetch_four_s;
    fetching [*4];
  endsequence

  sequence exec_three_s;
    (state_ff == AWC_S_EXEC) [*3] ##1 ready;
  endsequence

  sequence exec_four_s;
    (state_ff == AWC_S_EXEC) [*4] ##1 ready;
  endsequence

  short_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && (req.opcode == awc_pkg::OP_RR)) |=> fetch_two_s ##1 !fetching)
    else $error("short fetch not two cycles");

  mid_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && (req.opcode == awc_pkg::OP_GIM)) |=> fetch_three_s ##1 !fetching)
    else $error("register fetch not three cycles");

  long_fetch_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && dec.extended) |=> fetch_four_s ##1 !fetching)
    else $error("extended fetch not four cycles");

  direct_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(state_ff == AWC_S_EXEC) && exec_len_ff == awc_pkg::EXEC_DIRECT)
      |-> (state_ff == AWC_S_EXEC) [*3] ##1 ready)
    else $error("direct execution not three cycles");

  indirect_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && (req.opcode == awc_pkg::OP_RIR)) |=> fetch_two_s ##1 exec_four_s)
    else $error("indirect execution not four cycles");

  reg_indirect_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && ((req.opcode == awc_pkg::OP_GIG) || (req.opcode == awc_pkg::OP_IGIM)))
      |=> fetch_three_s ##1 exec_four_s)
    else $error("register indirect timing wrong");

  work_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && (req.opcode == awc_pkg::OP_RR)) |=> fetch_two_s ##1 exec_three_s)
    else $error("working register timing wrong");

  reg_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && ((req.opcode == awc_pkg::OP_GG) || (req.opcode == awc_pkg::OP_GIM)))
      |=> fetch_three_s ##1 exec_three_s)
    else $error("register direct timing wrong");

  ext_exec_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && ((req.opcode == awc_pkg::OP_XX) || (req.opcode == awc_pkg::OP_XIM)))
      |=> fetch_four_s ##1 exec_three_s)
    else $error("extended timing wrong");

  illegal_op_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && ((req.opcode < awc_pkg::OP_RR) || (req.opcode > awc_pkg::OP_XIM)))
      |=> (illegal_ff && ready))
    else $error("unknown opcode not refused");

  done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    done_ff |-> ready ##1 !done_ff)
    else $error("done not a single pulse in idle");

  sum_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    done_ff |-> (result_ff == 8'(dst_ff + src_ff + {7'h00, carry_ff})))
    else $error("result is not dst plus src plus carry");

  flag_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    done_ff |-> (!flags_ff[awc_pkg::FLAG_D] && flags_ff[awc_pkg::FLAG_Z] == (result_ff == 8'h00)
                 && flags_ff[awc_pkg::FLAG_S] == result_ff[7]))
    else $error("flags do not match result");

  flags_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !done_ff |-> $stable(flags_ff))
    else $error("flags changed without write-back");

  carry_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ready && start && dec.valid) |=> (carry_ff == $past(flags_in[awc_pkg::FLAG_C])))
    else $error("carry not captured at start");

endmodule : awc_exec

// [rtl/awc_pkg.sv]
package awc_pkg;

  // Opcodes of the add-with-carry family
  localparam logic [7:0] OP_RR = 8'h12;
  localparam logic [7:0] OP_RIR = 8'h13;
  localparam logic [7:0] OP_GG = 8'h14;
  localparam logic [7:0] OP_GIG = 8'h15;
  localparam logic [7:0] OP_GIM = 8'h16;
  localparam logic [7:0] OP_IGIM = 8'h17;
  localparam logic [7:0] OP_XX = 8'h18;
  localparam logic [7:0] OP_XIM = 8'h19;

  // Fetch and execution cycle counts
  localparam logic [2:0] FETCH_SHORT = 3'h2;
  localparam logic [2:0] FETCH_MID = 3'h3;
  localparam logic [2:0] FETCH_LONG = 3'h4;
  localparam logic [2:0] EXEC_DIRECT = 3'h3;
  localparam logic [2:0] EXEC_INDIRECT = 3'h4;

  // Flag bit positions in the flags byte
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Addressing mode pair of a decoded opcode
  typedef enum logic [7:0] {
    AWC_M_NONE = 8'h00,
    AWC_M_WORK_WORK = 8'h01,
    AWC_M_WORK_INDIRECT_WORK = 8'h02,
    AWC_M_REG_REG = 8'h04,
    AWC_M_REG_INDIRECT_REG = 8'h08,
    AWC_M_REG_IMMEDIATE = 8'h10,
    AWC_M_INDIRECT_REG_IMMEDIATE = 8'h20,
    AWC_M_EXT_EXT = 8'h40,
    AWC_M_EXT_IMMEDIATE = 8'h80
  } awc_mode_e;

  // Decoder result
  typedef struct packed {
    logic valid;
    logic extended;
    logic indirect;
    awc_mode_e mode;
    logic [2:0] fetch_cycles;
    logic [2:0] exec_cycles;
  } awc_dec_s;

  // Operand bundle presented with an instruction
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dst;
    logic [7:0] src;
  } awc_req_s;

endpackage : awc_pkg

// [rtl/awc_decode.sv]
`timescale 1ns/100ps
module awc_decode (
  input wire logic [7:0] opcode,
  output awc_pkg::awc_dec_s dec
);

  // Opcode to mode and cycle counts
  always_comb begin
    dec = '{valid: 1'b0, extended: 1'b0, indirect: 1'b0, mode: awc_pkg::AWC_M_NONE,
            fetch_cycles: 3'h0, exec_cycles: 3'h0};
    case (opcode)
      awc_pkg::OP_RR: dec = '{1'b1, 1'b0, 1'b0, awc_pkg::AWC_M_WORK_WORK,
                              awc_pkg::FETCH_SHORT, awc_pkg::EXEC_DIRECT};
      awc_pkg::OP_RIR: dec = '{1'b1, 1'b0, 1'b1, awc_pkg::AWC_M_WORK_INDIRECT_WORK,
                               awc_pkg::FETCH_SHORT, awc_pkg::EXEC_INDIRECT};
      awc_pkg::OP_GG: dec = '{1'b1, 1'b0, 1'b0, awc_pkg::AWC_M_REG_REG,
                              awc_pkg::FETCH_MID, awc_pkg::EXEC_DIRECT};
      awc_pkg::OP_GIG: dec = '{1'b1, 1'b0, 1'b1, awc_pkg::AWC_M_REG_INDIRECT_REG,
                               awc_pkg::FETCH_MID, awc_pkg::EXEC_INDIRECT};
      awc_pkg::OP_GIM: dec = '{1'b1, 1'b0, 1'b0, awc_pkg::AWC_M_REG_IMMEDIATE,
                               awc_pkg::FETCH_MID, awc_pkg::EXEC_DIRECT};
      awc_pkg::OP_IGIM: dec = '{1'b1, 1'b0, 1'b1, awc_pkg::AWC_M_INDIRECT_REG_IMMEDIATE,
                                awc_pkg::FETCH_MID, awc_pkg::EXEC_INDIRECT};
      awc_pkg::OP_XX: dec = '{1'b1, 1'b1, 1'b0, awc_pkg::AWC_M_EXT_EXT,
                              awc_pkg::FETCH_LONG, awc_pkg::EXEC_DIRECT};
      awc_pkg::OP_XIM: dec = '{1'b1, 1'b1, 1'b0, awc_pkg::AWC_M_EXT_IMMEDIATE,
                               awc_pkg::FETCH_LONG, awc_pkg::EXEC_DIRECT};
      default: ;
    endcase
  end

endmodule : awc_decode

// [testbench/awc_testbench.sv]
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  awc_pkg::awc_req_s req = '0;
  logic [7:0] flags_in = 8'h00;
  logic ready, busy, fetching, illegal_ff, done_ff, extended_ff;
  logic [7:0] result_ff, flags_ff, r1, r2;
  awc_pkg::awc_mode_e mode_ff;
  logic [7:0] lfsr = 8'h48;
  int n_mismatch = 0;
  int samples_checked = 0;

  // Free running clock
  always #25 clk = ~clk;

  awc_exec dut (.clk(clk), .rst_n(rst_n), .start(start), .req(req), .flags_in(flags_in), .ready(ready),
    .busy(busy), .fetching(fetching), .illegal_ff(illegal_ff), .done_ff(done_ff), .result_ff(result_ff),
    .flags_ff(flags_ff), .mode_ff(mode_ff), .extended_ff(extended_ff));

  // Galois shift register step
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    next_rand = {1'b0, s[7:1]} ^ (s[0] ? 8'hB8 : 8'h00);
  endfunction : next_rand

  // Expected flags byte after the add
  function automatic logic [7:0] exp_flags(input logic [7:0] d, input logic [7:0] s, input logic [7:0] f);
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, d} + {1'b0, s} + {8'h00, f[7]};
    low = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, f[7]};
    exp_flags = {sum[8], sum[7:0] == 8'h00, sum[7], (d[7] == s[7]) && (sum[7] != d[7]), 1'b0, low[4], f[1:0]};
  endfunction : exp_flags

  // Fetch and execution lengths by opcode
  function automatic logic [7:0] fetch_len(input logic [7:0] op);
    fetch_len = (op <= 8'h13) ? 8'h02 : (op <= 8'h17) ? 8'h03 : 8'h04;
  endfunction : fetch_len

  function automatic logic [7:0] exec_len(input logic [7:0] op);
    exec_len = (op == 8'h13 || op == 8'h15 || op == 8'h17) ? 8'h04 : 8'h03;
  endfunction : exec_len

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // One instruction; flags_in flips after the take and a refused start is pushed mid-run
  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input logic [7:0] f);
    int n;
    int fc;
    logic [7:0] old;
    @(posedge clk);
    start <= 1'b1;
    req <= '{opcode: op, dst: d, src: s};
    flags_in <= f;
    #1;
    chk({7'h00, done_ff}, 8'h00);
    @(posedge clk);
    start <= 1'b0;
    flags_in <= ~f;
    old = flags_ff;
    n = 0;
    fc = 0;
    while (n < 20) begin
      #1;
      if (done_ff === 1'b1)
        break;
      if (n == 1) begin
        chk(flags_ff, old);
        chk({7'h00, busy}, 8'h01);
      end
      fc += (fetching === 1'b1) ? 1 : 0;
      @(posedge clk);
      start <= (n == 1);
      n++;
    end
    chk({7'h00, busy}, 8'h00);
    chk(8'(n), fetch_len(op) + exec_len(op));
    chk(8'(fc), fetch_len(op));
    chk(result_ff, d + s + {7'h00, f[7]});
    chk(flags_ff, exp_flags(d, s, f));
    chk(mode_ff, 8'h01 << (op - 8'h12));
    chk({7'h00, extended_ff}, {7'h00, op >= 8'h18});
  endtask : run

  // Main sequence: reset, corner values per opcode, random traffic, bad opcode
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({7'h00, ready}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    chk(flags_ff, 8'h00);
    for (int i = 0; i < 8; i++) begin
      run(8'h12 + 8'(i), 8'hFF, 8'h00, 8'h80);
      run(8'h12 + 8'(i), 8'h7F, 8'h00, 8'h83);
      run(8'h12 + 8'(i), 8'h80, 8'h80, 8'h00);
    end
    for (int i = 0; i < 40; i++) begin
      lfsr = next_rand(lfsr);
      r1 = lfsr;
      lfsr = next_rand(lfsr);
      r2 = lfsr;
      lfsr = next_rand(lfsr);
      run(8'h12 + {5'h00, r1[2:0]}, r1, r2, lfsr);
    end
    @(posedge clk);
    start <= 1'b1;
    req.opcode <= 8'h20;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({7'h00, illegal_ff}, 8'h01);
    chk({7'h00, ready}, 8'h01);
    end_sim;
  end

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
endmodule : testbench
